// *** hdl/table_access_pkg.sv ***
package table_access_pkg;

  // ---------------------------------------------------------------
  // Quarter phases of one instruction cycle
  // ---------------------------------------------------------------
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;

  // ---------------------------------------------------------------
  // Opcode fields
  // ---------------------------------------------------------------
  localparam int OPC_SWAP_MSB = 15;
  localparam int OPC_SWAP_LSB = 10;
  localparam logic [5:0] OPC_SWAP = 6'h0e;
  localparam int OPC_TBL_MSB = 15;
  localparam int OPC_TBL_LSB = 3;
  localparam logic [12:0] OPC_TBL = 13'h0001;
  localparam int BIT_TBL_WRITE = 2;
  localparam int BIT_DEST = 9;
  localparam int BIT_ACCESS = 8;
  localparam int FILE_MSB = 7;
  localparam int MODE_MSB = 1;

  // ---------------------------------------------------------------
  // Pointer modes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_POSTINC = 2'h1;
  localparam logic [1:0] MODE_POSTDEC = 2'h2;
  localparam logic [1:0] MODE_PREINC = 2'h3;

  // ---------------------------------------------------------------
  // Widths, limits and reset values
  // ---------------------------------------------------------------
  localparam int PTR_W = 21;
  localparam int WORD_ADDR_W = PTR_W - 1;
  localparam logic [20:0] PTR_ONE = 21'h000001;
  localparam logic [20:0] PTR_RST = 21'h000000;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] INDEXED_MAX = 8'h5f;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SWAP,
    ST_TBL_DEC,
    ST_TBL_EXEC
  } state_t;

endpackage

// *** hdl/table_access_instruction_unit.sv ***
`timescale 1ns/100ps
module table_access_instruction_unit
  import table_access_pkg::*;
#(
  parameter int BANK_W = 4,
  parameter int HOLD_IDX_W = 6
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic ext_set_en,
  input wire logic [BANK_W-1:0] bank_select_reg,
  input wire logic [BANK_W+7:0] index_base,
  input wire logic [7:0] file_rd_data,
  input wire logic [15:0] pm_rd_data,
  input wire logic ptr_load_en,
  input wire logic [20:0] ptr_load_data,
  input wire logic latch_load_en,
  input wire logic [7:0] latch_load_data,
  output logic [1:0] q_phase_q,
  output logic busy_q,
  output logic [BANK_W+7:0] file_addr_q,
  output logic file_rd_en_q,
  output logic file_wr_en_q,
  output logic w_wr_en_q,
  output logic [7:0] result_q,
  output logic flags_wr_en_q,
  output logic pm_rd_en_q,
  output logic [19:0] pm_word_addr_q,
  output logic [20:0] table_pointer_q,
  output logic [7:0] table_latch_q,
  output logic hold_wr_en_q,
  output logic [HOLD_IDX_W-1:0] hold_idx_q,
  output logic [7:0] hold_data_q
);

  localparam int ADDR_W = BANK_W + 8;

  if (BANK_W < 1 || BANK_W > 8) begin : g_bad_bank
    $error("BANK_W out of range");
  end
  if (HOLD_IDX_W < 1 || HOLD_IDX_W > PTR_W) begin : g_bad_hold
    $error("HOLD_IDX_W out of range");
  end

  // ---------------------------------------------------------------
  // File address forming
  // ---------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] file_address(
    input logic [7:0] f,
    input logic a,
    input logic ext,
    input logic [BANK_W-1:0] bank,
    input logic [ADDR_W-1:0] base
  );
    logic [ADDR_W-1:0] r;
    if (a)
      r = {bank, f};
    else if (ext && (f <= INDEXED_MAX))
      r = ADDR_W'(base + {{BANK_W{1'b0}}, f});
    else if (f < ACCESS_SPLIT)
      r = {{BANK_W{1'b0}}, f};
    else
      r = {{BANK_W{1'b1}}, f};
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Quarter phase counter
  // ---------------------------------------------------------------
  logic [1:0] q_phase_d;

  always_comb
  begin
    q_phase_d = q_phase_q + PH_STEP;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      q_phase_q <= PH_Q1;
    else
      q_phase_q <= q_phase_d;
  end

  // ---------------------------------------------------------------
  // Instruction execution
  // ---------------------------------------------------------------
  state_t state_q, state_d;
  logic dest_q, dest_d;
  logic is_wr_q, is_wr_d;
  logic [1:0] mode_q, mode_d;
  logic [7:0] byte_q, byte_d;
  logic busy_d;
  logic [ADDR_W-1:0] file_addr_d;
  logic file_rd_en_d, file_wr_en_d, w_wr_en_d;
  logic [7:0] result_d;
  logic pm_rd_en_d;
  logic [19:0] pm_word_addr_d;
  logic [20:0] table_pointer_d;
  logic [7:0] table_latch_d;
  logic hold_wr_en_d;
  logic [HOLD_IDX_W-1:0] hold_idx_d;
  logic [7:0] hold_data_d;
  logic is_swap, is_tbl, accept;
  logic [7:0] pm_byte;

  assign is_swap = instr_word[OPC_SWAP_MSB:OPC_SWAP_LSB] == OPC_SWAP;
  assign is_tbl = instr_word[OPC_TBL_MSB:OPC_TBL_LSB] == OPC_TBL;
  assign accept = (state_q == ST_IDLE) && (q_phase_q == PH_Q1) && instr_valid;
  assign pm_byte = table_pointer_q[0] ? pm_rd_data[15:8] : pm_rd_data[7:0];

  always_comb
  begin
    state_d = state_q;
    dest_d = dest_q;
    is_wr_d = is_wr_q;
    mode_d = mode_q;
    byte_d = byte_q;
    busy_d = busy_q;
    file_addr_d = file_addr_q;
    file_rd_en_d = 1'b0;
    file_wr_en_d = 1'b0;
    w_wr_en_d = 1'b0;
    result_d = result_q;
    pm_rd_en_d = 1'b0;
    pm_word_addr_d = pm_word_addr_q;
    table_pointer_d = table_pointer_q;
    table_latch_d = table_latch_q;
    hold_wr_en_d = 1'b0;
    hold_idx_d = hold_idx_q;
    hold_data_d = hold_data_q;
    case (state_q)
      ST_IDLE:
      begin
        if (ptr_load_en)
          table_pointer_d = ptr_load_data;
        if (latch_load_en)
          table_latch_d = latch_load_data;
        if (accept && is_swap)
        begin
          state_d = ST_SWAP;
          dest_d = instr_word[BIT_DEST];
          file_rd_en_d = 1'b1;
          file_addr_d = file_address(instr_word[FILE_MSB:0], instr_word[BIT_ACCESS],
                                     ext_set_en, bank_select_reg, index_base);
        end
        else if (accept && is_tbl)
        begin
          state_d = ST_TBL_DEC;
          busy_d = 1'b1;
          is_wr_d = instr_word[BIT_TBL_WRITE];
          mode_d = instr_word[MODE_MSB:0];
        end
      end
      ST_SWAP:
      begin
        case (q_phase_q)
          PH_Q2:
            result_d = {file_rd_data[3:0], file_rd_data[7:4]};
          PH_Q3:
          begin
            file_wr_en_d = dest_q;
            w_wr_en_d = !dest_q;
          end
          PH_Q4:
            state_d = ST_IDLE;
          default:
            state_d = ST_SWAP;
        endcase
      end
      ST_TBL_DEC:
      begin
        if (q_phase_q == PH_Q4)
        begin
          state_d = ST_TBL_EXEC;
          if (mode_q == MODE_PREINC)
            table_pointer_d = table_pointer_q + PTR_ONE;
        end
      end
      ST_TBL_EXEC:
      begin
        case (q_phase_q)
          PH_Q1:
          begin
            pm_rd_en_d = !is_wr_q;
            pm_word_addr_d = table_pointer_q[PTR_W-1:1];
          end
          PH_Q2:
            byte_d = is_wr_q ? table_latch_q : pm_byte;
          PH_Q3:
          begin
            hold_wr_en_d = is_wr_q;
            hold_idx_d = table_pointer_q[HOLD_IDX_W-1:0];
            hold_data_d = byte_q;
          end
          default:
          begin
            state_d = ST_IDLE;
            busy_d = 1'b0;
            if (!is_wr_q)
              table_latch_d = byte_q;
            if (mode_q == MODE_POSTINC)
              table_pointer_d = table_pointer_q + PTR_ONE;
            else if (mode_q == MODE_POSTDEC)
              table_pointer_d = table_pointer_q - PTR_ONE;
          end
        endcase
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      dest_q <= 1'b0;
      is_wr_q <= 1'b0;
      mode_q <= MODE_NONE;
      byte_q <= LATCH_RST;
      busy_q <= 1'b0;
      file_addr_q <= '0;
      file_rd_en_q <= 1'b0;
      file_wr_en_q <= 1'b0;
      w_wr_en_q <= 1'b0;
      result_q <= LATCH_RST;
      flags_wr_en_q <= 1'b0;
      pm_rd_en_q <= 1'b0;
      pm_word_addr_q <= '0;
      table_pointer_q <= PTR_RST;
      table_latch_q <= LATCH_RST;
      hold_wr_en_q <= 1'b0;
      hold_idx_q <= '0;
      hold_data_q <= LATCH_RST;
    end
    else
    begin
      state_q <= state_d;
      dest_q <= dest_d;
      is_wr_q <= is_wr_d;
      mode_q <= mode_d;
      byte_q <= byte_d;
      busy_q <= busy_d;
      file_addr_q <= file_addr_d;
      file_rd_en_q <= file_rd_en_d;
      file_wr_en_q <= file_wr_en_d;
      w_wr_en_q <= w_wr_en_d;
      result_q <= result_d;
      flags_wr_en_q <= 1'b0;
      pm_rd_en_q <= pm_rd_en_d;
      pm_word_addr_q <= pm_word_addr_d;
      table_pointer_q <= table_pointer_d;
      table_latch_q <= table_latch_d;
      hold_wr_en_q <= hold_wr_en_d;
      hold_idx_q <= hold_idx_d;
      hold_data_q <= hold_data_d;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence swap_read_s;
    file_rd_en_q && (q_phase_q == PH_Q2);
  endsequence
  sequence table_read_s;
    pm_rd_en_q && (q_phase_q == PH_Q2);
  endsequence

  a_swap_result: assert property (
    swap_read_s ##2 (file_wr_en_q || w_wr_en_q)
      |-> result_q == {$past(file_rd_data[3:0], 2), $past(file_rd_data[7:4], 2)})
    else $error("swap result wrong");
  a_swap_dest: assert property (
    swap_read_s |-> ##2 ((file_wr_en_q == dest_q) && (w_wr_en_q == !dest_q)
      && (q_phase_q == PH_Q4)))
    else $error("swap destination wrong");
  a_bank_addr: assert property (
    accept && is_swap && instr_word[BIT_ACCESS]
      |=> file_addr_q == {$past(bank_select_reg), $past(instr_word[FILE_MSB:0])})
    else $error("banked address wrong");
  a_indexed_addr: assert property (
    accept && is_swap && !instr_word[BIT_ACCESS] && ext_set_en
      && (instr_word[FILE_MSB:0] <= INDEXED_MAX)
      |=> file_addr_q == ADDR_W'($past(index_base) + {{BANK_W{1'b0}},
        $past(instr_word[FILE_MSB:0])}))
    else $error("indexed address wrong");
  a_table_length: assert property (
    $rose(busy_q) |-> busy_q [*7] ##1 !busy_q)
    else $error("table instruction length wrong");
  a_latch_load: assert property (
    table_read_s |-> ##3 table_latch_q == $past(pm_byte, 3))
    else $error("latch load wrong");
  a_read_word_addr: assert property (
    table_read_s |-> pm_word_addr_q == table_pointer_q[PTR_W-1:1])
    else $error("read address wrong");
  a_ptr_update: assert property (
    $fell(busy_q) |-> table_pointer_q ==
      ((mode_q == MODE_POSTDEC) ? $past(table_pointer_q, 7) - PTR_ONE :
       (mode_q == MODE_NONE) ? $past(table_pointer_q, 7) :
       $past(table_pointer_q, 7) + PTR_ONE))
    else $error("pointer update wrong");
  a_hold_write: assert property (
    hold_wr_en_q |-> (q_phase_q == PH_Q4) && is_wr_q
      && (hold_idx_q == table_pointer_q[HOLD_IDX_W-1:0]) && !pm_rd_en_q)
    else $error("holding write wrong");
  a_write_keeps_latch: assert property (
    hold_wr_en_q |-> (hold_data_q == table_latch_q) && $stable(table_latch_q))
    else $error("table write disturbed latch");
  a_no_flags: assert property (
    busy_q || (state_q == ST_SWAP) |-> !flags_wr_en_q)
    else $error("status flags touched");

endmodule // table_access_instruction_unit

// *** verif/pm_model.sv ***
`timescale 1ns/100ps
module pm_model
#(
  parameter int IDX_W = 6
)(
  input wire logic sys_clk,
  input wire logic rd_en,
  input wire logic [19:0] word_addr,
  output logic [15:0] rd_data,
  input wire logic hold_wr_en,
  input wire logic [IDX_W-1:0] hold_idx,
  input wire logic [7:0] hold_data
);
  logic [15:0] last_q = 16'h0000;
  logic [7:0] hold_mem [2**IDX_W];

  function automatic logic [15:0] word_at(input logic [19:0] a);
    return {a[7:0] ^ 8'h3c, a[15:8] + a[7:0]};
  endfunction

  // Released read bus shows the inverse of its last value
  assign rd_data = rd_en ? word_at(word_addr) : ~last_q;

  always_ff @(posedge sys_clk)
  begin
    last_q <= rd_data;
    if (hold_wr_en)
    begin
      hold_mem[hold_idx] <= hold_data;
    end
  end
endmodule // pm_model

// *** verif/table_access_instruction_unit_bench.sv ***
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    samples_checked++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); \
    end \
  end
module table_access_instruction_unit_bench
  import table_access_pkg::*;
;
  logic sys_clk, rst_n, instr_valid, ext_set_en, ptr_load_en, latch_load_en;
  logic [15:0] instr_word, pm_rd_data;
  logic [3:0] bank_select_reg;
  logic [11:0] index_base, file_addr_q;
  logic [7:0] file_rd_data, latch_load_data, result_q, table_latch_q, hold_data_q;
  logic [20:0] ptr_load_data, table_pointer_q;
  logic [1:0] q_phase_q;
  logic busy_q, file_rd_en_q, file_wr_en_q, w_wr_en_q, flags_wr_en_q, pm_rd_en_q, hold_wr_en_q;
  logic [19:0] pm_word_addr_q;
  logic [5:0] hold_idx_q;
  int miscompares = 0;
  int samples_checked = 0;

  table_access_instruction_unit #(.BANK_W(4), .HOLD_IDX_W(6)) table_access_instruction_unit_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .ext_set_en(ext_set_en), .bank_select_reg(bank_select_reg), .index_base(index_base),
    .file_rd_data(file_rd_data), .pm_rd_data(pm_rd_data), .ptr_load_en(ptr_load_en),
    .ptr_load_data(ptr_load_data), .latch_load_en(latch_load_en),
    .latch_load_data(latch_load_data), .q_phase_q(q_phase_q), .busy_q(busy_q),
    .file_addr_q(file_addr_q), .file_rd_en_q(file_rd_en_q), .file_wr_en_q(file_wr_en_q),
    .w_wr_en_q(w_wr_en_q), .result_q(result_q), .flags_wr_en_q(flags_wr_en_q),
    .pm_rd_en_q(pm_rd_en_q), .pm_word_addr_q(pm_word_addr_q),
    .table_pointer_q(table_pointer_q), .table_latch_q(table_latch_q),
    .hold_wr_en_q(hold_wr_en_q), .hold_idx_q(hold_idx_q), .hold_data_q(hold_data_q));

  pm_model #(.IDX_W(6)) pm_model_inst (
    .sys_clk(sys_clk), .rd_en(pm_rd_en_q), .word_addr(pm_word_addr_q), .rd_data(pm_rd_data),
    .hold_wr_en(hold_wr_en_q), .hold_idx(hold_idx_q), .hold_data(hold_data_q));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk)
  begin
    if (rst_n)
      `CHK(flags_wr_en_q, 1'b0)
  end

  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Issue one word; returns at the Q1 edge that takes it
  // ---------------------------------------------------------------
  task automatic issue(input logic [15:0] w);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (!(q_phase_q === PH_Q4 && busy_q === 1'b0))
    begin
      n++;
      if (n > 40)
      begin
        miscompares++;
        stop_test();
      end
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
  endtask

  task automatic do_swap(input logic [7:0] f, input logic d, input logic a, input logic ext,
                         input logic [7:0] v);
    logic [11:0] ea;
    if (a)
      ea = {4'h5, f};
    else if (ext && f <= 8'h5f)
      ea = 12'h3a0 + {4'h0, f};
    else
      ea = (f < 8'h60) ? {4'h0, f} : {4'hf, f};
    @(posedge sys_clk);
    ext_set_en <= ext;
    file_rd_data <= v;
    issue({6'h0e, d, a, f});
    @(negedge sys_clk);
    `CHK(file_rd_en_q, 1'b1)
    `CHK(file_addr_q, ea)
    repeat (2) @(negedge sys_clk);
    `CHK(result_q, {v[3:0], v[7:4]})
    `CHK(w_wr_en_q, ~d)
    `CHK(file_wr_en_q, d)
  endtask

  task automatic do_table(input logic wr, input logic [1:0] m, input logic [20:0] p0,
                          input logic [7:0] lat);
    logic [20:0] pe, pf;
    logic [19:0] wa;
    logic [15:0] wd;
    pe = (m == MODE_PREINC) ? p0 + 21'h000001 : p0;
    pf = (m == MODE_POSTINC) ? pe + 21'h000001 : (m == MODE_POSTDEC) ? pe - 21'h000001 : pe;
    wa = pe[20:1];
    wd = {wa[7:0] ^ 8'h3c, wa[15:8] + wa[7:0]};
    @(posedge sys_clk);
    ptr_load_en <= 1'b1;
    ptr_load_data <= p0;
    latch_load_en <= 1'b1;
    latch_load_data <= lat;
    @(posedge sys_clk);
    ptr_load_en <= 1'b0;
    latch_load_en <= 1'b0;
    issue({13'h0001, wr, m});
    repeat (2) @(negedge sys_clk);
    `CHK(busy_q, 1'b1)
    repeat (3) @(negedge sys_clk);
    `CHK(pm_rd_en_q, ~wr)
    `CHK(q_phase_q, PH_Q2)
    if (!wr)
      `CHK(pm_word_addr_q, wa)
    repeat (2) @(negedge sys_clk);
    `CHK(hold_wr_en_q, wr)
    if (wr)
    begin
      `CHK(hold_idx_q, pe[5:0])
      `CHK(hold_data_q, lat)
    end
    @(negedge sys_clk);
    `CHK(busy_q, 1'b0)
    `CHK(table_pointer_q, pf)
    `CHK(table_latch_q, wr ? lat : (pe[0] ? wd[15:8] : wd[7:0]))
    if (wr)
      `CHK(pm_model_inst.hold_mem[pe[5:0]], lat)
  endtask

  task automatic do_ignored(input logic [15:0] w);
    issue(w);
    @(negedge sys_clk);
    `CHK({file_rd_en_q, w_wr_en_q, file_wr_en_q}, 3'h0)
    repeat (3) @(negedge sys_clk);
    `CHK(busy_q, 1'b0)
  endtask

  initial
  begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    ext_set_en = 1'b0;
    bank_select_reg = 4'h5;
    index_base = 12'h3a0;
    file_rd_data = 8'h00;
    ptr_load_en = 1'b0;
    ptr_load_data = 21'h000000;
    latch_load_en = 1'b0;
    latch_load_data = 8'h00;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    do_swap(8'h20, 1'b1, 1'b0, 1'b0, 8'h53);
    do_swap(8'h80, 1'b0, 1'b0, 1'b0, 8'ha7);
    do_swap(8'h5f, 1'b1, 1'b1, 1'b1, 8'h0f);
    do_swap(8'h5f, 1'b0, 1'b0, 1'b1, 8'hc4);
    do_swap(8'h60, 1'b0, 1'b0, 1'b1, 8'h91);
    for (int w = 0; w < 2; w++)
    begin
      for (int m = 0; m < 4; m++)
      begin
        do_table(w[0], m[1:0], 21'h00a356 + 21'(m), 8'h55 + 8'(m));
      end
    end
    do_table(1'b0, MODE_POSTINC, 21'h1fffff, 8'h12);
    do_table(1'b0, MODE_PREINC, 21'h1fffff, 8'h34);
    do_table(1'b1, MODE_POSTDEC, 21'h000000, 8'h77);
    do_table(1'b1, MODE_PREINC, 21'h01389a, 8'h34);
    do_ignored(16'h0010);
    do_ignored(16'h3000);
    stop_test();
  end
endmodule // table_access_instruction_unit_bench
